/* File: logic/ishd_evt_xfer.sv */
`timescale 1ns/10ps
`default_nettype none
module ishd_evt_xfer #(
  parameter int WIDTH = 11
) (
  input  wire logic             src_clk_in,
  input  wire logic             src_rst_b_in,
  input  wire logic             send_in,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic             dst_clk_in,
  input  wire logic             dst_rst_b_in,
  output logic                  valid_out,
  output logic      [WIDTH-1:0] data_out
);

  logic             tgl_reg;
  logic             tgl_next;
  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;
  logic             tgl_sync;
  logic             seen_reg;
  logic             valid_reg;
  logic [WIDTH-1:0] data_reg;
  logic             edge_seen;

  // Source side flips a toggle and holds the word; words are far apart so the hold is safe.
  always_comb begin
    tgl_next  = tgl_reg ^ send_in;
    hold_next = send_in ? data_in : hold_reg;
  end

  always_ff @(posedge src_clk_in or negedge src_rst_b_in) begin
    if (!src_rst_b_in) begin
      tgl_reg  <= 1'b0;
      hold_reg <= {WIDTH{1'b0}};
    end else begin
      tgl_reg  <= tgl_next;
      hold_reg <= hold_next;
    end
  end

  ishd_sync2 #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_tgl_sync (
    .clk_in   (dst_clk_in),
    .rst_b_in (dst_rst_b_in),
    .d_in     (tgl_reg),
    .q_out    (tgl_sync)
  );

  assign edge_seen = tgl_sync ^ seen_reg;

  // Destination side turns each toggle edge into a one-cycle pulse with the held word.
  always_ff @(posedge dst_clk_in or negedge dst_rst_b_in) begin
    if (!dst_rst_b_in) begin
      seen_reg  <= 1'b0;
      valid_reg <= 1'b0;
      data_reg  <= {WIDTH{1'b0}};
    end else begin
      seen_reg  <= tgl_sync;
      valid_reg <= edge_seen;
      data_reg  <= edge_seen ? hold_reg : data_reg;
    end
  end

  assign valid_out = valid_reg;
  assign data_out  = data_reg;

endmodule
`default_nettype wire

/* File: logic/ishd_pkg.sv */
`default_nettype none
package ishd_pkg;

  // ----------------------------------------------------------------
  // Reserved addresses and general call codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ISHD_GC_ADDR       = 7'h00;
  localparam logic [7:0] ISHD_START_BYTE    = 8'h01;
  localparam logic [6:0] ISHD_LEGACY_ADDR   = 7'h01;
  localparam logic [7:0] ISHD_CMD_RST_LOAD  = 8'h06;
  localparam logic [7:0] ISHD_CMD_SW_ADDR   = 8'h02;
  localparam logic [7:0] ISHD_CMD_HW_ADDR   = 8'h04;
  localparam logic [7:0] ISHD_CMD_FORBIDDEN = 8'h00;

  // ----------------------------------------------------------------
  // Byte framing and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ISHD_BYTE_BITS  = 4'h8;
  localparam logic [3:0] ISHD_CNT_RESET  = 4'h0;
  localparam logic [7:0] ISHD_BYTE_RESET = 8'h00;
  localparam logic       ISHD_LINE_IDLE  = 1'b1;
  localparam logic       ISHD_DRIVE_LOW  = 1'b0;
  localparam int         ISHD_EV_W       = 11;

  // ----------------------------------------------------------------
  // Event kinds reported to local logic
  // ----------------------------------------------------------------
  localparam logic [2:0] ISHD_EV_NONE      = 3'h0;
  localparam logic [2:0] ISHD_EV_GC_CMD    = 3'h1;
  localparam logic [2:0] ISHD_EV_HW_MASTER = 3'h2;
  localparam logic [2:0] ISHD_EV_GC_DATA   = 3'h3;
  localparam logic [2:0] ISHD_EV_OWN_DATA  = 3'h4;
  localparam logic [2:0] ISHD_EV_ADDR_SET  = 3'h5;

  // ----------------------------------------------------------------
  // Bus-side state machine, Gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ISHD_IDLE     = 3'b000,
    ISHD_ADDR     = 3'b001,
    ISHD_ADDR_ACK = 3'b011,
    ISHD_CMD      = 3'b010,
    ISHD_CMD_ACK  = 3'b110,
    ISHD_DATA     = 3'b111,
    ISHD_DATA_ACK = 3'b101,
    ISHD_IGNORE   = 3'b100
  } ishd_state_type;

endpackage
`default_nettype wire

/* File: logic/ishd_special_addr.sv */
// Summary of operation
// - Seven zero address bits with a zero direction bit form the general call.
// - Every start condition returns the bus logic to expecting a slave address.
// - With general calls disabled the general call address is left unacknowledged.
// - With general calls enabled the address is acknowledged and we become receiver.
// - Later general call bytes are acknowledged only when they can be handled.
// - The second byte bit zero selects command code or hardware master call.
// - Code 06 acknowledges, resets local logic and reloads programmable address bits.
// - Code 02 enters programming mode; the next byte sets programmable bits.
// - Code 04 latches the programmable address bits from pins without reset.
// - Undefined command codes with bit zero clear are not acknowledged.
// - Hardware call upper seven bits name the master; following data is routed.
// - A hardware master answering as slave uses its announced address.
// - Optional configuration of a hardware master through slave receiver mode.
// - After power up neither bus line is ever pulled low by default.
// - Polled receivers find the repeated start; hardware here just tracks starts.
// - The repeated start after the start byte resets the receiver.
// - The start byte is never acknowledged.
// - The legacy three-wire bus address is never answered, either direction.
// - After the stop ending a legacy transfer we accept new transfers again.
`timescale 1ns/10ps
`default_nettype none
module ishd_special_addr #(
  parameter logic [6:0] FIXED_ADDR = 7'h50,
  parameter int         PROG_W     = 3
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  link_clk_in,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_out,
  output logic                       scl_out,
  output logic                       scl_oe_out,
  input  wire logic     [PROG_W-1:0] addr_pins_in,
  input  wire logic                  gc_enable_in,
  input  wire logic                  data_accept_in,
  output logic                       event_valid_out,
  output logic                [2:0]  event_kind_out,
  output logic                [7:0]  event_data_out,
  output logic                       local_reset_out
);
  import ishd_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Own address is the fixed high part joined to the programmable low part.
  function automatic logic [6:0] ishd_own_addr(input logic [PROG_W-1:0] prog);
    logic [6:0] full;
    full = FIXED_ADDR;
    full[PROG_W-1:0] = prog;
    return full;
  endfunction

  // ----------------------------------------------------------------
  // Link domain reset and input synchronisers
  // ----------------------------------------------------------------
  logic              link_rst_b;
  logic              scl_s;
  logic              sda_s;
  logic [PROG_W-1:0] pins_s;
  logic [1:0]        ctl_s;

  // Reset is asserted at once and released on the link clock to avoid a ragged release.
  ishd_sync2 #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_link_rst (
    .clk_in   (link_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (1'b1),
    .q_out    (link_rst_b)
  );

  // Bus lines idle high, so their synchronisers reset high and no false start appears.
  ishd_sync2 #(
    .WIDTH     (2),
    .RESET_VAL (ISHD_LINE_IDLE)
  ) u_bus_sync (
    .clk_in   (link_clk_in),
    .rst_b_in (link_rst_b),
    .d_in     ({scl_in, sda_in}),
    .q_out    ({scl_s, sda_s})
  );

  // Static straps; released ahead of the bus logic so the first cycle catches them.
  ishd_sync2 #(
    .WIDTH     (PROG_W),
    .RESET_VAL (1'b0)
  ) u_pin_sync (
    .clk_in   (link_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (addr_pins_in),
    .q_out    (pins_s)
  );

  // Local enables are levels from the reference domain.
  ishd_sync2 #(
    .WIDTH     (2),
    .RESET_VAL (1'b0)
  ) u_ctl_sync (
    .clk_in   (link_clk_in),
    .rst_b_in (link_rst_b),
    .d_in     ({gc_enable_in, data_accept_in}),
    .q_out    (ctl_s)
  );

  // ----------------------------------------------------------------
  // Link domain bus state
  // ----------------------------------------------------------------
  ishd_state_type    state_reg;
  ishd_state_type    state_next;
  logic              scl_d_reg;
  logic              scl_d_next;
  logic              sda_d_reg;
  logic              sda_d_next;
  logic [3:0]        cnt_reg;
  logic [3:0]        cnt_next;
  logic [7:0]        shift_reg;
  logic [7:0]        shift_next;
  logic              ack_oe_reg;
  logic              ack_oe_next;
  logic              gc_mode_reg;
  logic              gc_mode_next;
  logic              hw_call_reg;
  logic              hw_call_next;
  logic              prog_mode_reg;
  logic              prog_mode_next;
  logic              reset_pend_reg;
  logic              reset_pend_next;
  logic              strap_init_reg;
  logic              strap_init_next;
  logic [PROG_W-1:0] prog_addr_reg;
  logic [PROG_W-1:0] prog_addr_next;
  logic              ev_send_reg;
  logic              ev_send_next;
  logic [2:0]        ev_kind_reg;
  logic [2:0]        ev_kind_next;
  logic [7:0]        ev_data_reg;
  logic [7:0]        ev_data_next;

  logic              start_det;
  logic              stop_det;
  logic              scl_rise;
  logic              scl_fall;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic              gc_en_s;
  logic              accept_s;

  assign gc_en_s  = ctl_s[1];
  assign accept_s = ctl_s[0];

  // Start and stop are data edges while the clock stays high.
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  // The eighth bit is complete at the falling clock edge after it was sampled.
  assign byte_done = scl_fall & (cnt_reg == ISHD_BYTE_BITS);
  assign rx_byte   = shift_reg;

  // Next-state logic for the whole bus side: framing, decoding and acknowledge.
  always_comb begin
    state_next      = state_reg;
    scl_d_next      = scl_s;
    sda_d_next      = sda_s;
    cnt_next        = cnt_reg;
    shift_next      = shift_reg;
    ack_oe_next     = ack_oe_reg;
    gc_mode_next    = gc_mode_reg;
    hw_call_next    = hw_call_reg;
    prog_mode_next  = prog_mode_reg;
    reset_pend_next = reset_pend_reg;
    strap_init_next = 1'b0;
    prog_addr_next  = prog_addr_reg;
    ev_send_next    = 1'b0;
    ev_kind_next    = ev_kind_reg;
    ev_data_next    = ev_data_reg;

    // Straps are caught once, in the first clocked cycle after reset release.
    if (strap_init_reg) begin
      prog_addr_next = pins_s;
    end

    // Bit sampling while a byte is being shifted in.
    if ((state_reg == ISHD_ADDR) || (state_reg == ISHD_CMD) || (state_reg == ISHD_DATA)) begin
      if (scl_rise) begin
        shift_next = {shift_reg[6:0], sda_s};
        cnt_next   = cnt_reg + 4'h1;
      end
    end

    unique case (state_reg)
      ISHD_IDLE: begin
      end
      ISHD_ADDR: begin
        if (byte_done) begin
          cnt_next = ISHD_CNT_RESET;
          if ((rx_byte[7:1] == ISHD_GC_ADDR) && !rx_byte[0]) begin
            if (gc_en_s) begin
              ack_oe_next  = 1'b1;
              gc_mode_next = 1'b1;
              state_next   = ISHD_ADDR_ACK;
            end else begin
              state_next = ISHD_IGNORE;
            end
          end else if (rx_byte == ISHD_START_BYTE) begin
            state_next = ISHD_IGNORE;
          end else if (rx_byte[7:1] == ISHD_LEGACY_ADDR) begin
            state_next = ISHD_IGNORE;
          end else if ((rx_byte[7:1] == ishd_own_addr(prog_addr_reg)) && !rx_byte[0]) begin
            ack_oe_next  = 1'b1;
            gc_mode_next = 1'b0;
            state_next   = ISHD_ADDR_ACK;
          end else begin
            state_next = ISHD_IGNORE;
          end
        end
      end
      ISHD_ADDR_ACK: begin
        if (scl_fall) begin
          ack_oe_next = 1'b0;
          state_next  = gc_mode_reg ? ISHD_CMD : ISHD_DATA;
        end
      end
      ISHD_CMD: begin
        if (byte_done) begin
          cnt_next     = ISHD_CNT_RESET;
          ev_data_next = rx_byte;
          if (rx_byte[0]) begin
            // Hardware master call: the upper bits identify the sender.
            ack_oe_next  = 1'b1;
            hw_call_next = 1'b1;
            ev_send_next = 1'b1;
            ev_kind_next = ISHD_EV_HW_MASTER;
            ev_data_next = {1'b0, rx_byte[7:1]};
            state_next   = ISHD_CMD_ACK;
          end else if (rx_byte == ISHD_CMD_RST_LOAD) begin
            ack_oe_next     = 1'b1;
            reset_pend_next = 1'b1;
            prog_mode_next  = 1'b0;
            prog_addr_next  = pins_s;
            ev_send_next    = 1'b1;
            ev_kind_next    = ISHD_EV_GC_CMD;
            state_next      = ISHD_CMD_ACK;
          end else if (rx_byte == ISHD_CMD_HW_ADDR) begin
            ack_oe_next    = 1'b1;
            prog_addr_next = pins_s;
            ev_send_next   = 1'b1;
            ev_kind_next   = ISHD_EV_GC_CMD;
            state_next     = ISHD_CMD_ACK;
          end else if (rx_byte == ISHD_CMD_SW_ADDR) begin
            ack_oe_next    = 1'b1;
            prog_mode_next = 1'b1;
            ev_send_next   = 1'b1;
            ev_kind_next   = ISHD_EV_GC_CMD;
            state_next     = ISHD_CMD_ACK;
          end else begin
            // The forbidden code and undefined codes fall here alike.
            state_next = ISHD_IGNORE;
          end
        end
      end
      ISHD_CMD_ACK: begin
        if (scl_fall) begin
          ack_oe_next = 1'b0;
          if (reset_pend_reg) begin
            // The bus logic drops out after the reset code and waits for the next start.
            reset_pend_next = 1'b0;
            state_next      = ISHD_IGNORE;
          end else begin
            state_next = ISHD_DATA;
          end
        end
      end
      ISHD_DATA: begin
        if (byte_done) begin
          cnt_next     = ISHD_CNT_RESET;
          ev_data_next = rx_byte;
          if (gc_mode_reg && prog_mode_reg) begin
            ack_oe_next    = 1'b1;
            prog_mode_next = 1'b0;
            prog_addr_next = rx_byte[PROG_W-1:0];
            ev_send_next   = 1'b1;
            ev_kind_next   = ISHD_EV_ADDR_SET;
            state_next     = ISHD_DATA_ACK;
          end else if ((!gc_mode_reg || hw_call_reg) && accept_s) begin
            ack_oe_next  = 1'b1;
            ev_send_next = 1'b1;
            ev_kind_next = gc_mode_reg ? ISHD_EV_GC_DATA : ISHD_EV_OWN_DATA;
            state_next   = ISHD_DATA_ACK;
          end else begin
            state_next = ISHD_IGNORE;
          end
        end
      end
      ISHD_DATA_ACK: begin
        if (scl_fall) begin
          ack_oe_next = 1'b0;
          state_next  = ISHD_DATA;
        end
      end
      ISHD_IGNORE: begin
        // Legacy format frames and unhandled bytes pass here without any drive.
        ack_oe_next = 1'b0;
      end
    endcase

    // A stop ends every transfer, legacy ones included.
    if (stop_det) begin
      state_next     = ISHD_IDLE;
      ack_oe_next    = 1'b0;
      cnt_next       = ISHD_CNT_RESET;
      gc_mode_next   = 1'b0;
      hw_call_next   = 1'b0;
      prog_mode_next = 1'b0;
    end

    // A start, repeated or not, overrides everything and expects an address byte.
    if (start_det) begin
      state_next      = ISHD_ADDR;
      ack_oe_next     = 1'b0;
      cnt_next        = ISHD_CNT_RESET;
      gc_mode_next    = 1'b0;
      hw_call_next    = 1'b0;
      reset_pend_next = 1'b0;
    end
  end

  // Registers of the bus side; the acknowledge drive is off in reset and until the first acknowledge.
  always_ff @(posedge link_clk_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      state_reg      <= ISHD_IDLE;
      scl_d_reg      <= ISHD_LINE_IDLE;
      sda_d_reg      <= ISHD_LINE_IDLE;
      cnt_reg        <= ISHD_CNT_RESET;
      shift_reg      <= ISHD_BYTE_RESET;
      ack_oe_reg     <= 1'b0;
      gc_mode_reg    <= 1'b0;
      hw_call_reg    <= 1'b0;
      prog_mode_reg  <= 1'b0;
      reset_pend_reg <= 1'b0;
      strap_init_reg <= 1'b1;
      prog_addr_reg  <= {PROG_W{1'b0}};
      ev_send_reg    <= 1'b0;
      ev_kind_reg    <= ISHD_EV_NONE;
      ev_data_reg    <= ISHD_BYTE_RESET;
    end else begin
      state_reg      <= state_next;
      scl_d_reg      <= scl_d_next;
      sda_d_reg      <= sda_d_next;
      cnt_reg        <= cnt_next;
      shift_reg      <= shift_next;
      ack_oe_reg     <= ack_oe_next;
      gc_mode_reg    <= gc_mode_next;
      hw_call_reg    <= hw_call_next;
      prog_mode_reg  <= prog_mode_next;
      reset_pend_reg <= reset_pend_next;
      strap_init_reg <= strap_init_next;
      prog_addr_reg  <= prog_addr_next;
      ev_send_reg    <= ev_send_next;
      ev_kind_reg    <= ev_kind_next;
      ev_data_reg    <= ev_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic sda_low_reg;
  logic scl_low_reg;
  logic scl_oe_reg;

  // Clock stretching is not used, so the clock line is never driven.
  always_ff @(posedge link_clk_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      sda_low_reg <= ISHD_DRIVE_LOW;
      scl_low_reg <= ISHD_DRIVE_LOW;
      scl_oe_reg  <= 1'b0;
    end else begin
      sda_low_reg <= ISHD_DRIVE_LOW;
      scl_low_reg <= ISHD_DRIVE_LOW;
      scl_oe_reg  <= 1'b0;
    end
  end

  assign sda_out    = sda_low_reg;
  assign sda_oe_out = ack_oe_reg;
  assign scl_out    = scl_low_reg;
  assign scl_oe_out = scl_oe_reg;

  // ----------------------------------------------------------------
  // Event crossing into the reference domain
  // ----------------------------------------------------------------
  logic                 xfer_valid;
  logic [ISHD_EV_W-1:0] xfer_data;

  // Bytes are tens of microseconds apart, far longer than the handshake needs.
  ishd_evt_xfer #(
    .WIDTH (ISHD_EV_W)
  ) u_evt_xfer (
    .src_clk_in   (link_clk_in),
    .src_rst_b_in (link_rst_b),
    .send_in      (ev_send_reg),
    .data_in      ({ev_kind_reg, ev_data_reg}),
    .dst_clk_in   (ref_clk_in),
    .dst_rst_b_in (rst_b_in),
    .valid_out    (xfer_valid),
    .data_out     (xfer_data)
  );

  logic local_reset_reg;
  logic local_reset_next;

  // The reset code becomes a one-cycle local reset pulse in the reference clock cycle after its event.
  always_comb begin
    local_reset_next = xfer_valid & (xfer_data[10:8] == ISHD_EV_GC_CMD)
                       & (xfer_data[7:0] == ISHD_CMD_RST_LOAD);
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      local_reset_reg <= 1'b0;
    end else begin
      local_reset_reg <= local_reset_next;
    end
  end

  assign event_valid_out = xfer_valid;
  assign event_kind_out  = xfer_data[10:8];
  assign event_data_out  = xfer_data[7:0];
  assign local_reset_out = local_reset_reg;

endmodule
`default_nettype wire

/* File: logic/ishd_sync2.sv */
`timescale 1ns/10ps
`default_nettype none
module ishd_sync2 #(
  parameter int   WIDTH     = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // Two flops; only the second one reads the first, so metastability settles there.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= {WIDTH{RESET_VAL}};
      q_reg    <= {WIDTH{RESET_VAL}};
    end else begin
      meta_reg <= d_in;
      q_reg    <= meta_reg;
    end
  end

  assign q_out = q_reg;

endmodule
`default_nettype wire

/* File: verif/ishd_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none
module ishd_bus_master #(
  parameter int H = 64
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_out
);
  // ----
  // Master model; a high output means released, the pull-up then wins.
  // ----
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Long wait first, so a slave still acknowledging has let go before SCL rises.
  task automatic start;
    sda_out <= 1'b1;
    wt(3 * H);
    scl_out <= 1'b1;
    wt(2 * H);
    sda_out <= 1'b0;
    wt(2 * H);
    scl_out <= 1'b0;
  endtask
  task automatic stop;
    sda_out <= 1'b0;
    wt(H);
    scl_out <= 1'b1;
    wt(2 * H);
    sda_out <= 1'b1;
    wt(2 * H);
  endtask
  // Whole bytes only, and the ninth clock is always given.
  task automatic xbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      wt(H);
      sda_out <= (i < 0) ? 1'b1 : v[i];
      wt(2 * H);
      scl_out <= 1'b1;
      wt(2 * H);
      ack = ~sda_in;
      scl_out <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/ishd_special_addr_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ishd_special_addr_props
  import ishd_pkg::*;
#(
  parameter logic [6:0] FIXED_ADDR = 7'h50,
  parameter int         PROG_W     = 3
) (
  input wire logic              ref_clk_in,
  input wire logic              rst_b_in,
  input wire logic              link_clk_in,
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe_out,
  input wire logic              scl_out,
  input wire logic              scl_oe_out,
  input wire logic [PROG_W-1:0] addr_pins_in,
  input wire logic              gc_enable_in,
  input wire logic              data_accept_in,
  input wire logic              event_valid_out,
  input wire logic [2:0]        event_kind_out,
  input wire logic [7:0]        event_data_out,
  input wire logic              local_reset_out
);
  // ----
  // Checks. A held-low clock line would block every other device, so it is watched outside reset.
  // ----
  line_free_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !scl_oe_out && !scl_out && !sda_out) else $error("bus line held low");
  ev_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    event_valid_out |=> !event_valid_out) else $error("event pulse too long");
  ev_kind_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    event_valid_out |-> event_kind_out inside {[3'h1:3'h5]}) else $error("bad event kind");
  reset_load_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    local_reset_out |-> $past(event_valid_out) && event_kind_out == ISHD_EV_GC_CMD
      && event_data_out == ISHD_CMD_RST_LOAD) else $error("local reset without reset code");
  rst_single_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    local_reset_out |=> !local_reset_out) else $error("local reset too long");
  hw_addr_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    event_valid_out && event_kind_out == ISHD_EV_HW_MASTER |-> !event_data_out[7]) else $error("bad master address");
  gc_code_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    event_valid_out && event_kind_out == ISHD_EV_GC_CMD |-> event_data_out inside {8'h02, 8'h04, 8'h06})
    else $error("undefined code reported");
  ack_len_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    $rose(sda_oe_out) |-> sda_oe_out [*8]) else $error("acknowledge too short");
  ack_quiet_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    scl_in && $past(scl_in) |-> $stable(sda_oe_out)) else $error("data moved while clock high");
  cover property (@(posedge ref_clk_in) local_reset_out);
  cover property (@(posedge ref_clk_in) event_valid_out && event_kind_out == ISHD_EV_HW_MASTER);
  cover property (@(posedge link_clk_in) $rose(sda_oe_out));
endmodule
bind ishd_special_addr ishd_special_addr_props #(.FIXED_ADDR(FIXED_ADDR), .PROG_W(PROG_W)) u_props (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .addr_pins_in(addr_pins_in), .gc_enable_in(gc_enable_in),
  .data_accept_in(data_accept_in), .event_valid_out(event_valid_out), .event_kind_out(event_kind_out),
  .event_data_out(event_data_out), .local_reset_out(local_reset_out));
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ishd_pkg::*;
  logic       clk, lclk, rst_b, gc_en, acc, m_scl, m_sda, oe, so, scl_o, scl_oe, ev_v, lrst;
  logic [2:0] pins, ev_k;
  logic [7:0] ev_d, b;
  int         err_count, checked, ev_n, rst_n, n0;
  wire        sda_w = m_sda & ~oe;
  wire        scl_w = m_scl & ~scl_oe;
  // ----
  // Clocks, design, partner and event counting.
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #62.5 lclk = ~lclk;
  end
  ishd_special_addr dut (.ref_clk_in(clk), .rst_b_in(rst_b), .link_clk_in(lclk), .scl_in(scl_w),
    .sda_in(sda_w), .sda_out(so), .sda_oe_out(oe), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .addr_pins_in(pins), .gc_enable_in(gc_en), .data_accept_in(acc), .event_valid_out(ev_v),
    .event_kind_out(ev_k), .event_data_out(ev_d), .local_reset_out(lrst));
  ishd_bus_master mst (.clk_in(clk), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
  always_ff @(posedge clk) begin
    ev_n <= ev_n + int'(ev_v);
    rst_n <= rst_n + int'(lrst);
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] v, input logic ea);
    logic a;
    mst.xbyte(v, a);
    chk({7'h0, a}, {7'h0, ea});
  endtask
  // New events since the last look, then the latest one.
  task automatic evchk(input int n, input logic [2:0] k, input logic [7:0] d);
    chk(8'(ev_n - n0), 8'(n));
    if (n > 0) begin
      chk({5'h0, ev_k}, {5'h0, k});
      chk(ev_d, d);
    end
    n0 = ev_n;
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("Error at %0t: run timed out", $time);
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    gc_en = 1'b0;
    acc = 1'b1;
    pins = 3'h5;
    void'($urandom(32'h2fb7));
    repeat (8) @(posedge clk);
    chk({7'h0, oe | scl_oe}, 8'h00);
    pins <= 3'($urandom);
    rst_b <= 1'b1;
    repeat (100) @(posedge clk);
    mst.start();
    send(8'h00, 1'b0);
    gc_en <= 1'b1;
    mst.start();
    send(8'h00, 1'b1);
    send(ISHD_CMD_RST_LOAD, 1'b1);
    evchk(1, ISHD_EV_GC_CMD, ISHD_CMD_RST_LOAD);
    chk(8'(rst_n), 8'h01);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? ISHD_CMD_HW_ADDR : (i == 1) ? ISHD_CMD_FORBIDDEN : {1'b0, 6'($urandom_range(4, 63)), 1'b0};
      mst.start();
      send(8'h00, 1'b1);
      send(b, i == 0);
      evchk(int'(i == 0), ISHD_EV_GC_CMD, b);
    end
    mst.start();
    send(8'h00, 1'b1);
    send(ISHD_CMD_SW_ADDR, 1'b1);
    evchk(1, ISHD_EV_GC_CMD, ISHD_CMD_SW_ADDR);
    b = 8'($urandom);
    send(b, 1'b1);
    mst.start();
    send({4'ha, b[2:0], 1'b0}, 1'b1);
    send(b, 1'b1);
    evchk(2, ISHD_EV_OWN_DATA, b);
    mst.start();
    send(ISHD_START_BYTE, 1'b0);
    mst.start();
    send(8'h00, 1'b1);
    for (int i = 0; i < 2; i++) begin
      mst.start();
      send({ISHD_LEGACY_ADDR, 1'(i)}, 1'b0);
      mst.stop();
      mst.start();
      send(8'h00, 1'b1);
    end
    b = {7'($urandom_range(8, 119)), 1'b1};
    mst.start();
    send(8'h00, 1'b1);
    send(b, 1'b1);
    evchk(1, ISHD_EV_HW_MASTER, {1'b0, b[7:1]});
    b = 8'($urandom);
    send(b, 1'b1);
    evchk(1, ISHD_EV_GC_DATA, b);
    acc <= 1'b0;
    send(8'($urandom), 1'b0);
    evchk(0, ISHD_EV_NONE, 8'h00);
    mst.stop();
    test_done();
  end
endmodule
`default_nettype wire
